// ==== pmcs_sequencer.sv ====
// pmcs_sequencer: conversion sequencer of the current, voltage and power monitor.
// assumes an adc front end on the same clock: adcStart_r begins one conversion of
// adcChannel_r, a new start aborts the old one, and adcDone pulses once with adcData.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module pmcs_sequencer import pmcs_pkg::*; (
    input wire logic clock,
    input wire logic reset,
    input wire pmcs_req_t req,
    output logic [15:0] readData_r,
    input wire logic adcDone,
    input wire logic signed [15:0] adcData,
    output logic adcStart_r,
    output pmcs_chan_t adcChannel_r,
    output logic adcEnable_r,
    output logic conversionReadyFlag_r
);
    typedef enum logic [2:0] {ST_PDOWN, ST_WAKE, ST_IDLE, ST_START, ST_WAIT_SHUNT, ST_WAIT_BUS} pmcs_state_t;

    pmcs_state_t state_r;
    logic [15:0] config_r;
    logic [15:0] cal_r;
    logic [11:0] wakeCnt_r;
    logic [10:0] issueCnt_r;
    logic [10:0] accCnt_r;
    logic [10:0] sampleCount;
    logic signed [15:0] shuntRaw_r;
    logic signed [15:0] busRaw_r;
    logic calcGo_r;
    logic [1:0] modeSel;
    logic contMode;
    logic [3:0] avgShift;
    logic cfgWrite;
    logic cfgOff;
    logic statusRead;
    logic setDone;
    logic doneOk;
    logic lastIssue;
    logic flush;
    logic accLast;
    logic publish;
    logic calcValid;
    pmcs_set_t rawSet;
    pmcs_set_t calcSet;
    pmcs_set_t results;
    logic [3:0][15:0] calcVec;
    logic [3:0][15:0] resVec;

    ////////////////////////////////////////////////////////////////////////////////
    // decode of the configuration and the register port
    assign modeSel = config_r[CFG_MODE_LSB+1:CFG_MODE_LSB];
    assign contMode = config_r[CFG_MODE_LSB+MODE_CONT_BIT];
    assign avgShift = AVG_SHIFT[config_r[CFG_AVG_LSB+2:CFG_AVG_LSB]];
    assign sampleCount = 11'h001 << avgShift;
    assign cfgWrite = req.write && (req.addr == ADDR_CONFIG);
    assign cfgOff = (req.wdata[CFG_MODE_LSB+1:CFG_MODE_LSB] == MODE_OFF);
    assign statusRead = req.read && (req.addr == ADDR_STATUS);
    // a configuration write abandons the run in flight; stale math must not leak into the next
    assign flush = cfgWrite;
    assign lastIssue = (issueCnt_r == sampleCount - 11'h001);
    // a done seen beside our own start belongs to the conversion that start aborts
    assign doneOk = adcDone && !adcStart_r;

    // a set ends on the final conversion its mode asks for
    always_comb begin
        setDone = 1'b0;
        if (doneOk && !cfgWrite) begin
            if (state_r == ST_WAIT_SHUNT && modeSel == MODE_SHUNT) begin
                setDone = 1'b1;
            end else if (state_r == ST_WAIT_BUS) begin
                setDone = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration and calibration; writes are honoured in every state
    always_ff @(posedge clock) begin
        if (reset) begin
            config_r <= CONFIG_RESET;
            cal_r <= CAL_RESET;
        end else if (req.write) begin
            if (req.addr == ADDR_CONFIG) begin
                config_r <= req.wdata & CONFIG_WMASK;
            end
            if (req.addr == ADDR_CAL) begin
                cal_r <= req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // conversion state machine; reads never reach it, only writes and the adc do
    always_ff @(posedge clock) begin
        if (reset) begin
            state_r <= ST_WAKE;
        end else if (cfgWrite) begin
            if (cfgOff) begin
                state_r <= ST_PDOWN;
            end else if (state_r == ST_PDOWN || state_r == ST_WAKE) begin // a write never cuts wake short
                state_r <= ST_WAKE;
            end else begin
                state_r <= ST_START;
            end
        end else begin
            case (state_r)
                ST_PDOWN: state_r <= ST_PDOWN;
                ST_WAKE: begin
                    if (wakeCnt_r == 12'h000) begin
                        state_r <= ST_START;
                    end
                end
                ST_IDLE: state_r <= ST_IDLE;
                ST_START: begin
                    state_r <= (modeSel == MODE_BUS) ? ST_WAIT_BUS : ST_WAIT_SHUNT;
                end
                ST_WAIT_SHUNT: begin
                    if (doneOk && modeSel == MODE_BOTH) begin
                        state_r <= ST_WAIT_BUS;
                    end else if (setDone) begin
                        state_r <= (!contMode && lastIssue) ? ST_IDLE : ST_START;
                    end
                end
                ST_WAIT_BUS: begin
                    if (setDone) begin
                        state_r <= (!contMode && lastIssue) ? ST_IDLE : ST_START;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // wake counter, loaded at reset and on leaving power-down
    always_ff @(posedge clock) begin
        if (reset) begin
            wakeCnt_r <= WAKE_LOAD;
        end else if (state_r != ST_WAKE) begin
            wakeCnt_r <= WAKE_LOAD;
        end else if (wakeCnt_r != 12'h000) begin
            wakeCnt_r <= wakeCnt_r - 12'h001;
        end
    end

    // count of sets issued, only single-shot modes stop on it
    always_ff @(posedge clock) begin
        if (reset || flush) begin
            issueCnt_r <= '0;
        end else if (setDone) begin
            issueCnt_r <= lastIssue ? 11'h000 : issueCnt_r + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // adc command; the bus start follows the shunt result in the same edge
    always_ff @(posedge clock) begin
        if (reset) begin
            adcStart_r <= 1'b0;
            adcChannel_r <= ADC_SHUNT;
            adcEnable_r <= 1'b1;
        end else begin
            adcStart_r <= 1'b0;
            adcEnable_r <= !(cfgWrite ? cfgOff : state_r == ST_PDOWN); // front end biased off in power-down
            if (!cfgWrite && state_r == ST_START) begin
                adcStart_r <= 1'b1;
                adcChannel_r <= (modeSel == MODE_BUS) ? ADC_BUS : ADC_SHUNT;
            end else if (!cfgWrite && state_r == ST_WAIT_SHUNT && doneOk && modeSel == MODE_BOTH) begin
                adcStart_r <= 1'b1;
                adcChannel_r <= ADC_BUS;
            end
        end
    end

    // raw codes pass without scaling, so each keeps its fixed weight
    always_ff @(posedge clock) begin
        if (reset) begin
            shuntRaw_r <= '0;
            busRaw_r <= '0;
        end else if (doneOk && !cfgWrite) begin
            if (state_r == ST_WAIT_SHUNT) begin
                shuntRaw_r <= adcData;
            end
            if (state_r == ST_WAIT_BUS) begin
                busRaw_r <= adcData;
            end
        end
    end

    // math is launched once a set is in and runs while the next conversion starts
    always_ff @(posedge clock) begin
        if (reset) begin
            calcGo_r <= 1'b0;
        end else begin
            calcGo_r <= setDone;
        end
    end

    assign rawSet = '{shunt: shuntRaw_r, bus: busRaw_r, current: 16'h0000, power: 16'h0000};

    pmcs_calc calc_u (
        .clock(clock),
        .reset(reset),
        .flush(flush),
        .go(calcGo_r && !flush),
        .raw(rawSet),
        .cal(cal_r),
        .set_r(calcSet),
        .valid_r(calcValid)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // averaging over the four result channels
    assign accLast = (accCnt_r == sampleCount - 11'h001);
    assign publish = calcValid && accLast && !flush;
    assign calcVec = calcSet;

    always_ff @(posedge clock) begin
        if (reset || flush) begin
            accCnt_r <= '0;
        end else if (calcValid) begin
            accCnt_r <= accLast ? 11'h000 : accCnt_r + 11'h001;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_avg
            pmcs_avg avg_u (
                .clock(clock),
                .reset(reset),
                .flush(flush),
                .add(calcValid && !flush),
                .last(accLast),
                .sample(calcVec[ch]),
                .shift(avgShift),
                .avg_r(resVec[ch])
            );
        end
    endgenerate

    // outputs only move on publish since each channel loads on its last sample
    assign results = resVec;

    ////////////////////////////////////////////////////////////////////////////////
    // ready flag; a publish in the same cycle as a clear wins
    always_ff @(posedge clock) begin
        if (reset) begin
            conversionReadyFlag_r <= 1'b0;
        end else if (publish) begin
            conversionReadyFlag_r <= 1'b1;
        end else if (statusRead || (cfgWrite && !cfgOff)) begin
            conversionReadyFlag_r <= 1'b0;
        end
    end

    // read data stands one cycle after the strobe; unmapped indices read zero
    always_ff @(posedge clock) begin
        if (reset) begin
            readData_r <= '0;
        end else if (req.read) begin
            case (req.addr)
                ADDR_CONFIG: readData_r <= config_r;
                ADDR_SHUNT: readData_r <= results.shunt;
                ADDR_BUS: readData_r <= results.bus;
                ADDR_POWER: readData_r <= results.power;
                ADDR_CURRENT: readData_r <= results.current;
                ADDR_CAL: readData_r <= cal_r;
                ADDR_STATUS: begin
                    readData_r <= '0;
                    readData_r[STAT_READY_BIT] <= conversionReadyFlag_r;
                    readData_r[STAT_BUSY_BIT] <= (state_r != ST_IDLE) && (state_r != ST_PDOWN);
                end
                default: readData_r <= '0;
            endcase
        end else begin
            readData_r <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    alternate_bus_a: assert property (@(posedge clock) disable iff (reset)
        (state_r == ST_WAIT_SHUNT && doneOk && modeSel == MODE_BOTH && !cfgWrite)
        |=> (adcStart_r && adcChannel_r == ADC_BUS))
        else $error("bus conversion did not follow shunt");
    shunt_only_a: assert property (@(posedge clock) disable iff (reset)
        (adcStart_r && modeSel == MODE_SHUNT) |-> adcChannel_r == ADC_SHUNT)
        else $error("bus converted in shunt-only mode");
    results_hold_a: assert property (@(posedge clock) disable iff (reset)
        !$past(publish) |-> $stable(results))
        else $error("results moved without a finished average");
    ready_cause_a: assert property (@(posedge clock) disable iff (reset)
        $rose(conversionReadyFlag_r) |-> $past(publish))
        else $error("ready flag set without a finished set");
    cfg_clear_a: assert property (@(posedge clock) disable iff (reset)
        (cfgWrite && !cfgOff && !publish) |=> !conversionReadyFlag_r)
        else $error("configuration write left ready flag set");
    pdown_keep_a: assert property (@(posedge clock) disable iff (reset)
        (cfgWrite && cfgOff && conversionReadyFlag_r) |=> conversionReadyFlag_r)
        else $error("power-down write cleared ready flag");
    status_clear_a: assert property (@(posedge clock) disable iff (reset)
        (statusRead && !publish && !req.write) |=> !conversionReadyFlag_r)
        else $error("status read left ready flag set");
    stopped_quiet_a: assert property (@(posedge clock) disable iff (reset)
        (state_r == ST_IDLE && !cfgWrite) [*2] |-> !adcStart_r)
        else $error("conversion started after single shot ended");
    pdown_quiet_a: assert property (@(posedge clock) disable iff (reset)
        (state_r == ST_PDOWN && !cfgWrite) |=> (!adcStart_r && !adcEnable_r && state_r == ST_PDOWN))
        else $error("activity in power-down");
    wake_time_a: assert property (@(posedge clock) disable iff (reset)
        (state_r == ST_WAKE && wakeCnt_r == WAKE_LOAD && !cfgWrite) |=> (state_r == ST_WAKE) [*8])
        else $error("wake time cut short");
    read_harmless_a: assert property (@(posedge clock) disable iff (reset)
        (req.read && !req.write && !adcDone && (state_r == ST_WAIT_SHUNT || state_r == ST_WAIT_BUS))
        |=> state_r == $past(state_r))
        else $error("register read disturbed conversion");
endmodule : pmcs_sequencer

// ==== pmcs_pkg.sv ====
// pmcs_pkg: constants, field layouts and carrier types of the power monitor sequencer.
// assumes one 50 MHz clock shared by the sequencer, the register port and the adc front end.
package pmcs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_MHZ = 50;
    localparam int WAKE_TIME_US = 40;
    localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_MHZ;
    localparam logic [11:0] WAKE_LOAD = 12'(WAKE_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // register indices on the plain port
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_SHUNT = 4'h1;
    localparam logic [3:0] ADDR_BUS = 4'h2;
    localparam logic [3:0] ADDR_POWER = 4'h3;
    localparam logic [3:0] ADDR_CURRENT = 4'h4;
    localparam logic [3:0] ADDR_CAL = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;

    ////////////////////////////////////////////////////////////////////////////////
    // configuration and status fields
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_AVG_LSB = 9;
    localparam int MODE_CONT_BIT = 2;
    localparam logic [15:0] CONFIG_RESET = 16'h0007;
    localparam logic [15:0] CONFIG_WMASK = 16'h0e07;
    localparam logic [15:0] CAL_RESET = 16'h0000;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SHUNT = 2'h1;
    localparam logic [1:0] MODE_BUS = 2'h2;
    localparam logic [1:0] MODE_BOTH = 2'h3;
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // result weights: shunt 2500 nV/bit, bus 1250 uV/bit, raw codes pass unscaled
    localparam int SHUNT_LSB_NV = 2500;
    localparam int BUS_LSB_UV = 1250;
    localparam int CUR_SHIFT = 11;
    localparam int PWR_SHIFT = 15;
    localparam int ACC_W = 27;
    localparam logic [3:0] AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha};

    ////////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef enum logic {ADC_SHUNT, ADC_BUS} pmcs_chan_t;

    typedef struct packed {
        logic signed [15:0] shunt;
        logic signed [15:0] bus;
        logic signed [15:0] current;
        logic signed [15:0] power;
    } pmcs_set_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic write;
        logic read;
    } pmcs_req_t;

endpackage : pmcs_pkg

// ==== pmcs_calc.sv ====
// pmcs_calc: two-stage current and power pipeline beside the converter.
// assumes go is a one-cycle pulse and raw stays valid in that cycle.
`timescale 1ns/1ns
module pmcs_calc import pmcs_pkg::*; (
    input wire logic clock,
    input wire logic reset,
    input wire logic flush,
    input wire logic go,
    input wire pmcs_set_t raw,
    input wire logic [15:0] cal,
    output pmcs_set_t set_r,
    output logic valid_r
);
    pmcs_set_t st1_r;
    logic v1_r;
    logic signed [32:0] curProd;
    logic [15:0] curMag;
    logic [31:0] pwrProd;

    // current from shunt code and calibration; an unloaded calibration forces zero
    assign curProd = raw.shunt * $signed({1'b0, cal});
    assign curMag = st1_r.current[15] ? 16'(-st1_r.current) : st1_r.current;
    assign pwrProd = curMag * st1_r.bus;

    always_ff @(posedge clock) begin
        if (reset || flush) begin
            st1_r <= '0;
            v1_r <= 1'b0;
        end else begin
            v1_r <= go;
            if (go) begin
                st1_r <= raw;
                st1_r.current <= (cal == 16'h0000) ? 16'h0000 : curProd[CUR_SHIFT+15:CUR_SHIFT];
            end
        end
    end

    // power from that current and the bus code; its weight follows the current weight
    always_ff @(posedge clock) begin
        if (reset || flush) begin
            set_r <= '0;
            valid_r <= 1'b0;
        end else begin
            valid_r <= v1_r;
            if (v1_r) begin
                set_r <= st1_r;
                set_r.power <= pwrProd[PWR_SHIFT+15:PWR_SHIFT];
            end
        end
    end

    calc_latency_a: assert property (@(posedge clock) disable iff (reset || flush) go |=> ##1 valid_r)
        else $error("calc result not two cycles after go");
    cal_zero_a: assert property (@(posedge clock) disable iff (reset)
        (go && cal == 16'h0000 && !flush) |=> ##1 (!valid_r || set_r.current == 16'h0000))
        else $error("current not zero without calibration");
endmodule : pmcs_calc

// ==== pmcs_avg.sv ====
// pmcs_avg: one accumulator channel that publishes the power-of-two average of a run.
// assumes add is a one-cycle pulse and last marks the final sample of a run.
`timescale 1ns/1ns
module pmcs_avg import pmcs_pkg::*; (
    input wire logic clock,
    input wire logic reset,
    input wire logic flush,
    input wire logic add,
    input wire logic last,
    input wire logic signed [15:0] sample,
    input wire logic [3:0] shift,
    output logic signed [15:0] avg_r
);
    logic signed [ACC_W-1:0] acc_r;
    logic signed [ACC_W-1:0] sum;
    logic first_r;

    // the first sample of a run loads instead of adding, so no clear cycle is spent
    assign sum = (first_r ? ACC_W'(0) : acc_r) + ACC_W'(sample);

    always_ff @(posedge clock) begin
        if (reset || flush) begin
            acc_r <= '0;
            first_r <= 1'b1;
        end else if (add) begin
            acc_r <= sum;
            first_r <= last;
        end
    end

    // division is a shift; counts are powers of two so it is exact to floor
    always_ff @(posedge clock) begin
        if (reset) begin
            avg_r <= '0;
        end else if (add && last && !flush) begin
            avg_r <= 16'(sum >>> shift);
        end
    end

    avg_single_a: assert property (@(posedge clock) disable iff (reset)
        (add && last && first_r && !flush && shift == 4'h0) |=> avg_r == $past(sample))
        else $error("single sample average differs from sample");
endmodule : pmcs_avg

// ==== pmcs_adc_model.sv ====
// pmcs_adc_model: behavioural adc front end facing the sequencer's conversion link.
// assumes start is a one-cycle pulse on the sequencer's clock; done answers after delay+1 edges.
`timescale 1ns/1ns
module pmcs_adc_model import pmcs_pkg::*; (
    input wire logic clock,
    input wire logic reset,
    input wire logic start,
    input wire pmcs_chan_t channel,
    input wire logic [7:0] delay,
    input wire logic signed [15:0] shuntCode,
    input wire logic signed [15:0] busCode,
    output logic done,
    output logic signed [15:0] data
);
    logic [7:0] left_r;
    logic busy_r;
    logic flip_r;
    pmcs_chan_t chan_r;
    ////////////////////////////////////////
    // conversion timer; data toggles outside done so a stale code is never mistaken for a result
    always_ff @(posedge clock) begin
        done <= 1'b0;
        data <= ~data;
        if (reset) begin
            busy_r <= 1'b0;
            flip_r <= 1'b0;
            left_r <= 8'h00;
            data <= 16'h0000;
        end else if (start) begin
            busy_r <= 1'b1; // a new start aborts the running one
            chan_r <= channel;
            left_r <= delay;
        end else if (busy_r && left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end else if (busy_r) begin
            busy_r <= 1'b0;
            done <= 1'b1;
            // shunt code alternates by two so averaging shows in the result
            if (chan_r == ADC_SHUNT) begin
                data <= shuntCode + {14'h0000, flip_r, 1'b0};
                flip_r <= ~flip_r;
            end else begin
                data <= busCode;
            end
        end
    end
endmodule : pmcs_adc_model

// ==== tb_top.sv ====
// tb_top: register-port tests of the conversion sequencer against a behavioural adc.
// assumes the register map and link timing of the sequencer package.
`timescale 1ns/1ns
module tb_top import pmcs_pkg::*; ;
    logic clock, reset, adcDone, adcStart, adcEnable, flag;
    pmcs_req_t req;
    logic [15:0] readData;
    logic signed [15:0] adcData, shuntCode, busCode;
    pmcs_chan_t adcChannel;
    logic [7:0] delay;
    int errCount, cmpCount, starts, busStarts;
    logic [15:0] cfgTab [3] = '{16'h0001, 16'h0001, 16'h0002};
    logic [15:0] busTab [3] = '{16'h4000, 16'h4000, 16'h2000};

    pmcs_sequencer uut (.clock(clock), .reset(reset), .req(req), .readData_r(readData), .adcDone(adcDone),
        .adcData(adcData), .adcStart_r(adcStart), .adcChannel_r(adcChannel), .adcEnable_r(adcEnable),
        .conversionReadyFlag_r(flag));
    pmcs_adc_model adc (.clock(clock), .reset(reset), .start(adcStart), .channel(adcChannel), .delay(delay),
        .shuntCode(shuntCode), .busCode(busCode), .done(adcDone), .data(adcData));

    ////////////////////////////////////////
    // clock, watchdog and start counter
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        errCount++; // a hang counts as a mismatch
        completeRun;
    end
    always @(posedge clock) begin
        if (adcStart === 1'b1) begin
            starts++;
            busStarts += (adcChannel === ADC_BUS);
        end
    end

    ////////////////////////////////////////
    // register port tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmpCount++;
        if (got !== exp) begin
            errCount++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        req <= '{a, 16'h0000, 1'b0, 1'b0};
        #1;
    endtask : wr
    task automatic rdc(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m);
        @(posedge clock);
        req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clock);
        req <= '{a, 16'h0000, 1'b0, 1'b0};
        #1 chk(readData & m, exp);
    endtask : rdc
    // bounded wait so a flag that never rises ends as a mismatch, not a hang
    task automatic waitFlag;
        for (int n = 0; n < 5000 && flag !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        chk({15'h0000, flag}, 16'h0001);
    endtask : waitFlag
    task completeRun;
        $display("comparisons %0d, mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : completeRun

    ////////////////////////////////////////
    // main sequence
    initial begin
        errCount = 0;
        cmpCount = 0;
        starts = 0;
        busStarts = 0;
        reset = 1'b1;
        req = '0;
        delay = 8'd40;
        shuntCode = 16'sd100;
        busCode = 16'sh4000;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        rdc(ADDR_CONFIG, 16'h0007, 16'hffff);
        rdc(ADDR_CAL, 16'h0000, 16'hffff);
        chk({15'h0000, adcEnable}, 16'h0001);
        waitFlag;
        rdc(ADDR_CURRENT, 16'h0000, 16'hffff);
        rdc(ADDR_POWER, 16'h0000, 16'hffff);
        rdc(ADDR_BUS, 16'h4000, 16'hffff);
        rdc(ADDR_STATUS, 16'h0001, 16'h0001);
        rdc(ADDR_STATUS, 16'h0000, 16'h0001);
        // single shot, both channels, four samples, fast adc
        delay <= 8'd3;
        wr(ADDR_CAL, 16'h0800);
        wr(ADDR_CONFIG, 16'h0203);
        starts = 0;
        busStarts = 0;
        chk({15'h0000, flag}, 16'h0000);
        rdc(ADDR_STATUS, 16'h0002, 16'h0002);
        waitFlag;
        repeat (60) @(posedge clock);
        #1 chk(16'(starts), 16'd8);
        chk(16'(busStarts), 16'd4);
        rdc(ADDR_SHUNT, 16'd101, 16'hffff);
        rdc(ADDR_BUS, 16'h4000, 16'hffff);
        rdc(ADDR_CURRENT, 16'd101, 16'hffff);
        rdc(ADDR_POWER, 16'd50, 16'hffff);
        // single-channel shots; the repeated shunt write must run again
        busCode <= 16'sh2000;
        for (int i = 0; i < 3; i++) begin
            starts = 0;
            busStarts = 0;
            wr(ADDR_CONFIG, cfgTab[i]);
            waitFlag;
            repeat (60) @(posedge clock);
            #1 chk(16'(starts), 16'd1);
            chk(16'(busStarts), (i == 2) ? 16'd1 : 16'd0);
            rdc(ADDR_BUS, busTab[i], 16'hffff);
        end
        // power-down keeps the flag and the registers, then wakes slowly
        wr(ADDR_CONFIG, 16'h0000);
        starts = 0;
        chk({15'h0000, flag}, 16'h0001);
        chk({15'h0000, adcEnable}, 16'h0000);
        wr(ADDR_CAL, 16'h1234);
        chk(readData, 16'h0000);
        rdc(ADDR_CAL, 16'h1234, 16'hffff);
        rdc(4'h7, 16'h0000, 16'hffff);
        rdc(ADDR_STATUS, 16'h0000, 16'h0002);
        repeat (300) @(posedge clock);
        #1 chk(16'(starts), 16'd0);
        wr(ADDR_CONFIG, 16'h0007);
        chk({15'h0000, flag}, 16'h0000);
        rdc(ADDR_STATUS, 16'h0002, 16'h0002);
        wr(ADDR_CONFIG, 16'h0007);
        repeat (1990) @(posedge clock);
        #1 chk(16'(starts), 16'd0);
        repeat (40) @(posedge clock);
        #1 chk({15'h0000, starts != 0}, 16'h0001);
        completeRun;
    end
endmodule : tb_top
